// File: logic/gpx_cfg.svh
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

// ==========================================
// bus address
`define GPX_ADDR_PREFIX 4'h4

// ==========================================
// command codes, low three bits of the command byte
`define GPX_CMD_IN0 3'h0
`define GPX_CMD_IN1 3'h1
`define GPX_CMD_OUT0 3'h2
`define GPX_CMD_OUT1 3'h3
`define GPX_CMD_POL0 3'h4
`define GPX_CMD_POL1 3'h5
`define GPX_CMD_DIR0 3'h6
`define GPX_CMD_DIR1 3'h7
`define GPX_CMD_RST 3'h0

// ==========================================
// reset values
`define GPX_OUT_RST 16'hffff
`define GPX_POL_RST 16'h0000
`define GPX_DIR_RST 16'hffff

// ==========================================
// bit count that closes a byte on the serial link
`define GPX_BIT_LAST 4'h8

`endif

// File: logic/gpx_pkg.sv
package gpx_pkg;

   // ==========================================
   // serial slave states, gray along the usual path except GPX_ADDR_ACK to GPX_R_DATA and GPX_R_ACK to GPX_IDLE
   typedef enum logic [3:0] {
      GPX_IDLE = 4'h0,
      GPX_ADDR = 4'h1,
      GPX_ADDR_ACK = 4'h3,
      GPX_CMD = 4'h2,
      GPX_CMD_ACK = 4'h6,
      GPX_W_DATA = 4'h7,
      GPX_W_ACK = 4'h5,
      GPX_R_DATA = 4'h4,
      GPX_R_ACK = 4'hc
   } gpx_state_t;

   // ==========================================
   // writable register set, bit n is pin n (port 1 in the upper byte)
   typedef struct packed {
      logic [15:0] dir;
      logic [15:0] pol;
      logic [15:0] out;
   } gpx_regs_t;

endpackage : gpx_pkg

// File: logic/gpx_sync.sv
`timescale 1ns/10ps

module gpx_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;

   // ==========================================
   // two stages; the first is read only by the second
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_r <= RST_VAL;
         q_o <= RST_VAL;
      end
      else if (ce_i)
      begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end

endmodule : gpx_sync

// File: logic/gpx_expander.sv
`timescale 1ns/10ps
`include "gpx_cfg.svh"

// Overview of operation
// - sixteen pins in two ports, each with direction, input, output, polarity bytes
// - after reset every pin is an input with its driver off
// - each direction bit picks input or driven output for its pin
// - input register holds sampled level, output register holds latched drive level
// - a set polarity bit inverts the reported input bit
// - every register reads back over the serial link
// - reset restores all registers and restarts the serial slave machine
// - alert asserts while any input differs from its stored input bit
// - alert is open drain, active low, pulled low only when asserted
// - slave address is a fixed prefix plus three address-select pins
// - output pins drive both high and low levels
// - responds to seven-bit addresses 0x20 to 0x27
// - address byte lsb one means read, zero means write
// - first written byte after address is the command, three bits pick register
// - last command keeps selecting the register for later reads
module gpx_expander (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic addr_sel_0_i,
   input wire logic addr_sel_1_i,
   input wire logic addr_sel_2_i,
   input wire logic [15:0] pin_i,
   output logic [15:0] pin_o,
   output logic [15:0] pin_oe_n_o,
   output logic alert_o,
   output logic alert_oe_n_o
);
   import gpx_pkg::*;
   // ==========================================
   // input synchronisers
   logic [1:0] link_s;
   logic [18:0] pins_s;
   logic scl_s, sda_s, scl_d_r, sda_d_r;
   logic [2:0] addr_sel_s;
   logic [15:0] pin_s;
   // scl and sda idle high, so they leave reset high to avoid a false edge
   gpx_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_link_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .d_i({scl_i, sda_i}),
      .q_o(link_s)
   );
   // addr pins are static, synchronised only to keep them clean
   gpx_sync #(
      .W(19),
      .RST_VAL(19'h00000)
   ) u_pin_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .d_i({addr_sel_2_i, addr_sel_1_i, addr_sel_0_i, pin_i}),
      .q_o(pins_s)
   );
   assign scl_s = link_s[1];
   assign sda_s = link_s[0];
   assign addr_sel_s = pins_s[18:16];
   assign pin_s = pins_s[15:0];
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   // ==========================================
   // link events
   logic scl_rise, scl_fall, start_ev, stop_ev, byte_end;
   logic [3:0] cnt_r;
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign start_ev = scl_s && scl_d_r && !sda_s && sda_d_r;
   assign stop_ev = scl_s && scl_d_r && sda_s && !sda_d_r;
   assign byte_end = scl_fall && (cnt_r == `GPX_BIT_LAST);
   // ==========================================
   // slave state
   gpx_state_t state_r;
   logic [7:0] shreg_r, tx_r, rd_byte;
   logic [2:0] ptr_r;
   logic rw_r, nack_r, addr_hit, wr_en, load_tx;
   logic [15:0] in_now, snap_r;
   logic [1:0] prime_r;
   gpx_regs_t regs_r;
   assign addr_hit = (shreg_r[7:1] == {`GPX_ADDR_PREFIX, addr_sel_s});
   assign wr_en = byte_end && (state_r == GPX_W_DATA);
   assign load_tx = scl_fall && (((state_r == GPX_ADDR_ACK) && rw_r) || ((state_r == GPX_R_ACK) && !nack_r));
   assign in_now = pin_s ^ regs_r.pol;
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state_r <= GPX_IDLE;
      else if (ce_i)
      begin
         if (start_ev)
            state_r <= GPX_ADDR;
         else if (stop_ev)
            state_r <= GPX_IDLE;
         else if (scl_fall)
         begin
            case (state_r)
               GPX_ADDR:
                  if (byte_end)
                     state_r <= addr_hit ? GPX_ADDR_ACK : GPX_IDLE;
               GPX_ADDR_ACK:
                  state_r <= rw_r ? GPX_R_DATA : GPX_CMD;
               GPX_CMD:
                  if (byte_end)
                     state_r <= GPX_CMD_ACK;
               GPX_CMD_ACK, GPX_W_ACK:
                  state_r <= GPX_W_DATA;
               GPX_W_DATA:
                  if (byte_end)
                     state_r <= GPX_W_ACK;
               GPX_R_DATA:
                  if (byte_end)
                     state_r <= GPX_R_ACK;
               GPX_R_ACK:
                  state_r <= nack_r ? GPX_IDLE : GPX_R_DATA;
               default:
                  state_r <= GPX_IDLE;
            endcase
         end
      end
   end
   // bit counter, cleared at each byte and ack boundary
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cnt_r <= 4'h0;
      else if (ce_i)
      begin
         if (start_ev || byte_end)
            cnt_r <= 4'h0;
         else if (scl_fall && (state_r == GPX_ADDR_ACK || state_r == GPX_CMD_ACK ||
                               state_r == GPX_W_ACK || state_r == GPX_R_ACK))
            cnt_r <= 4'h0;
         else if (scl_rise && cnt_r != `GPX_BIT_LAST)
            cnt_r <= cnt_r + 4'h1;
      end
   end
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         shreg_r <= 8'h00;
      else if (ce_i && scl_rise)
         shreg_r <= {shreg_r[6:0], sda_s};
   end
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rw_r <= 1'b0;
         nack_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (byte_end && state_r == GPX_ADDR)
            rw_r <= shreg_r[0];
         if (scl_rise && state_r == GPX_R_ACK)
            nack_r <= sda_s;
      end
   end
   // pointer survives between transfers so reads reuse it
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ptr_r <= `GPX_CMD_RST;
      else if (ce_i && byte_end && state_r == GPX_CMD)
         ptr_r <= shreg_r[2:0];
   end
   // ==========================================
   // register file
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         regs_r.out <= `GPX_OUT_RST;
         regs_r.pol <= `GPX_POL_RST;
         regs_r.dir <= `GPX_DIR_RST;
      end
      else if (ce_i && wr_en)
      begin
         case (ptr_r)
            `GPX_CMD_OUT0: regs_r.out[7:0] <= shreg_r;
            `GPX_CMD_OUT1: regs_r.out[15:8] <= shreg_r;
            `GPX_CMD_POL0: regs_r.pol[7:0] <= shreg_r;
            `GPX_CMD_POL1: regs_r.pol[15:8] <= shreg_r;
            `GPX_CMD_DIR0: regs_r.dir[7:0] <= shreg_r;
            `GPX_CMD_DIR1: regs_r.dir[15:8] <= shreg_r;
            default: ;
         endcase
      end
   end
   // read mux over all eight registers
   always_comb
   begin
      case (ptr_r)
         `GPX_CMD_IN0: rd_byte = in_now[7:0];
         `GPX_CMD_IN1: rd_byte = in_now[15:8];
         `GPX_CMD_OUT0: rd_byte = regs_r.out[7:0];
         `GPX_CMD_OUT1: rd_byte = regs_r.out[15:8];
         `GPX_CMD_POL0: rd_byte = regs_r.pol[7:0];
         `GPX_CMD_POL1: rd_byte = regs_r.pol[15:8];
         `GPX_CMD_DIR0: rd_byte = regs_r.dir[7:0];
         default: rd_byte = regs_r.dir[15:8];
      endcase
   end
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         tx_r <= 8'h00;
      else if (ce_i)
      begin
         if (load_tx)
            tx_r <= rd_byte;
         else if (scl_fall && state_r == GPX_R_DATA && !byte_end)
            tx_r <= {tx_r[6:0], 1'b0};
      end
   end
   // ==========================================
   // stored input state and change alert
   // snapshot tracks the pins until the synchroniser has filled,
   // else its reset zeros would read as a change right after reset
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         snap_r <= 16'h0000;
         prime_r <= 2'h0;
      end
      else if (ce_i)
      begin
         if (prime_r != 2'h3)
         begin
            prime_r <= prime_r + 2'h1;
            snap_r <= in_now;
         end
         else if (load_tx && ptr_r == `GPX_CMD_IN0)
            snap_r[7:0] <= in_now[7:0];
         else if (load_tx && ptr_r == `GPX_CMD_IN1)
            snap_r[15:8] <= in_now[15:8];
      end
   end
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         alert_oe_n_o <= 1'b1;
      else if (ce_i)
         alert_oe_n_o <= !((prime_r == 2'h3) && (in_now != snap_r));
   end
   // ==========================================
   // pin and sda drivers
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sda_oe_n_o <= 1'b1;
      else if (ce_i)
      begin
         case (state_r)
            GPX_ADDR_ACK, GPX_CMD_ACK, GPX_W_ACK: sda_oe_n_o <= 1'b0;
            GPX_R_DATA: sda_oe_n_o <= tx_r[7] || (cnt_r == `GPX_BIT_LAST);
            default: sda_oe_n_o <= 1'b1;
         endcase
      end
   end
   // open-drain lines only ever pull low
   assign sda_o = 1'b0;
   assign alert_o = 1'b0;
   assign pin_o = regs_r.out;
   assign pin_oe_n_o = regs_r.dir;
endmodule : gpx_expander

// File: verification/gpx_expander_sva.sv
`timescale 1ns/10ps
// ==========================================
// port checker
module gpx_expander_sva (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic addr_sel_0_i,
   input wire logic addr_sel_1_i,
   input wire logic addr_sel_2_i,
   input wire logic [15:0] pin_i,
   input wire logic [15:0] pin_o,
   input wire logic [15:0] pin_oe_n_o,
   input wire logic alert_o,
   input wire logic alert_oe_n_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_scl_high;
      scl_i ##1 scl_i;
   endsequence
   property p_rst_val;
      $rose(resetn_i) |-> pin_o == 16'hffff && pin_oe_n_o == 16'hffff;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
   property p_od;
      sda_o == 1'b0 && alert_o == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("open drain value driven high");
   property p_dir;
      $changed(pin_oe_n_o) |-> !$past(scl_i, 2);
   endproperty
   a_dir: assert property (p_dir) else $error("direction moved outside a write");
   property p_out;
      $changed(pin_o) |-> !$past(scl_i, 2);
   endproperty
   a_out: assert property (p_out) else $error("output latch moved outside a write");
   property p_pull;
      $fell(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 3);
   endproperty
   a_pull: assert property (p_pull) else $error("data pulled while clock high");
   property p_hold;
      s_scl_high |-> $stable(sda_oe_n_o);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved while clock high");
   property p_freeze;
      !ce_i |=> $stable(pin_o) && $stable(pin_oe_n_o) && $stable(alert_oe_n_o);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");
   property p_alert;
      $changed(alert_oe_n_o) && $past(resetn_i, 6) && $past(ce_i, 4) |->
         $past(pin_i, 2) != $past(pin_i, 6) || !$past(scl_i, 2);
   endproperty
   a_alert: assert property (p_alert) else $error("alert moved without cause");
endmodule : gpx_expander_sva

bind gpx_expander gpx_expander_sva u_gpx_expander_sva (.*);

// File: verification/gpx_i2c_master.sv
`timescale 1ns/10ps
// ==========================================
// bus master, open drain: 0 pulls, 1 releases to the pull-up
module gpx_i2c_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   // clock low 6 cycles, high 2; the device answers 4 after a fall
   task automatic bit_x(input logic b, output logic r);
      tick(1);
      sda_o = b;
      tick(5);
      scl_o = 1'b1;
      tick(2);
      r = sda_i;
      scl_o = 1'b0;
   endtask : bit_x
   // wait out a late ack release before raising the clock
   task automatic start();
      tick(1);
      sda_o = 1'b1;
      tick(6);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b0;
   endtask : start
   task automatic stop();
      tick(1);
      sda_o = 1'b0;
      tick(5);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b1;
      tick(4);
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, nack);
   endtask : wbyte
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(nack, r);
   endtask : rbyte
endmodule : gpx_i2c_master

// File: verification/gpx_expander_tb.sv
`timescale 1ns/10ps
module gpx_expander_tb;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ce_i = 1'b1;
   logic [2:0] asel = 3'h0;
   logic [15:0] ext = 16'h0000;
   logic [15:0] pin_o, pin_oe_n_o, pin_i;
   logic sda_o, sda_oe_n_o, alert_o, alert_oe_n_o, scl, sda_m, sda_i, ack;
   logic [31:0] seed = 32'ha803;
   logic [7:0] mdl [8];
   logic [7:0] rb;
   logic [6:0] me;
   int fails = 0;
   int compares = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   assign sda_i = sda_m & (sda_oe_n_o | sda_o);
   assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext);
   assign me = {4'h4, asel};
   gpx_i2c_master u_gpx_i2c_master (.clk_i(sys_clk_i), .sda_i(sda_i), .scl_o(scl), .sda_o(sda_m));
   gpx_expander u_gpx_expander (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .scl_i(scl),
      .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .addr_sel_0_i(asel[0]), .addr_sel_1_i(asel[1]),
      .addr_sel_2_i(asel[2]), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .alert_o(alert_o),
      .alert_oe_n_o(alert_oe_n_o));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   function automatic logic [7:0] exp_reg(input logic [2:0] c);
      logic [15:0] w;
      w = ({mdl[7], mdl[6]} & ext | ~{mdl[7], mdl[6]} & {mdl[3], mdl[2]}) ^ {mdl[5], mdl[4]};
      return c == 3'h0 ? w[7:0] : c == 3'h1 ? w[15:8] : mdl[c];
   endfunction : exp_reg
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s exp %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic rst_model();
      mdl = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
      chk("dir rst", pin_oe_n_o, 16'hffff);
      chk("out rst", pin_o, 16'hffff);
   endtask : rst_model
   task automatic wr(input logic [6:0] a, input logic [2:0] c, input logic [7:0] d);
      u_gpx_i2c_master.start();
      u_gpx_i2c_master.wbyte({a, 1'b0}, ack);
      chk("addr ack", ack, a != me);
      if (!ack)
      begin
         u_gpx_i2c_master.wbyte({5'h15, c}, ack);
         u_gpx_i2c_master.wbyte(d, ack);
         if (c > 3'h1)
            mdl[c] = d;
      end
      u_gpx_i2c_master.stop();
   endtask : wr
   task automatic rd(input logic [2:0] c);
      u_gpx_i2c_master.start();
      u_gpx_i2c_master.wbyte({me, 1'b0}, ack);
      u_gpx_i2c_master.wbyte({5'h00, c}, ack);
      u_gpx_i2c_master.start();
      u_gpx_i2c_master.wbyte({me, 1'b1}, ack);
      u_gpx_i2c_master.rbyte(1'b0, rb);
      chk("read", rb, exp_reg(c));
      u_gpx_i2c_master.rbyte(1'b1, rb);
      chk("reread", rb, exp_reg(c));
      u_gpx_i2c_master.stop();
   endtask : rd
   task automatic gap(input logic [15:0] flip, input logic a);
      ext ^= flip;
      repeat (6) @(negedge sys_clk_i);
      chk("alert", alert_oe_n_o, a);
   endtask : gap
   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (60000) @(posedge sys_clk_i);
      fails++;
      finish_test();
   end
   initial
   begin
      repeat (2) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      @(negedge sys_clk_i);
      rst_model();
      for (int i = 0; i < 16; i++)
      begin
         asel = i[2:0];
         ext = {rnd(), rnd()};
         repeat (6) @(negedge sys_clk_i);
         wr({4'h4, asel ^ 3'(i > 7)}, i[2:0], rnd());
         wr(me, i[2:0], rnd());
         rd(i[2:0]);
         chk("dir", pin_oe_n_o, {mdl[7], mdl[6]});
         chk("out", pin_o, {mdl[3], mdl[2]});
      end
      wr(me, 3'h6, 8'hff);
      wr(me, 3'h7, 8'hff);
      rd(3'h0);
      rd(3'h1);
      gap(16'h0000, 1'b1);
      gap(16'h0010, 1'b0);
      gap(16'h0010, 1'b1);
      gap(16'h0100, 1'b0);
      rd(3'h0);
      gap(16'h0000, 1'b0);
      rd(3'h1);
      gap(16'h0000, 1'b1);
      ce_i = 1'b0;
      gap(16'h0001, 1'b1);
      ce_i = 1'b1;
      gap(16'h0000, 1'b0);
      wr(me, 3'h2, 8'h5a);
      resetn_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      @(negedge sys_clk_i);
      rst_model();
      repeat (6) @(negedge sys_clk_i);
      chk("alert rst", alert_oe_n_o, 1'b1);
      rd(3'h2);
      rd(3'h4);
      finish_test();
   end
endmodule : gpx_expander_tb
